// File: logic/bpa_pkg.sv
package bpa_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 25;
    // impression window limits, set by the forms thickness control
    localparam int IMP_MIN_US = 235;
    localparam int IMP_MAX_US = 435;
    localparam int IMP_MIN_CYC = (IMP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IMP_MAX_CYC = (IMP_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int THICK_STEPS = 7;
    localparam int IMP_STEP_CYC = (IMP_MAX_CYC - IMP_MIN_CYC) / THICK_STEPS;
    // width of home and carriage advance pulses
    localparam int PULSE_NS = 1000;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // carriage oscillator: running step and the two delayed stopping steps
    localparam int CARR_STEP_US = 1000;
    localparam int CARR_STEP_CYC = (CARR_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam int CARR_DECEL_US = 2000;
    localparam int CARR_DECEL_CYC = (CARR_DECEL_US * 1000) / CLK_PERIOD_NS;
    localparam logic [1:0] CARR_TAIL_STEPS = 2'h2;
    localparam int INC_PER_LINE = 8;
    // belt timing marks and oscillator ramp
    localparam int BELT_MARK_CYC = 2000;
    localparam int BELT_START_DIV = 400;
    localparam int BELT_RUN_DIV = 100;
    localparam int HAMMERS = 66;
    localparam int GROUP_SIZE = 22;
    localparam int GROUPS = 3;
    // register map
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] INTERVAL_ADDR = 4'h8;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int CTRL_THICK_LSB = 0;
    localparam int ST_MOTION = 0;
    localparam int ST_CARRIAGE = 1;
    localparam int ST_GAP = 2;
    localparam int ST_HCHK_LSB = 3;
    localparam int ST_THROAT = 6;
    localparam int ST_COVER = 7;
    localparam int ST_FORMS = 8;
    localparam int ST_THERMAL = 9;
    localparam int ST_SUPPLY = 10;
    localparam int REG_W = 32;
endpackage

// File: logic/bpa_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a group of pin inputs
module bpa_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end
endmodule

// File: logic/bpa_oneshot.sv
`timescale 1ns/100ps
// retriggerable single shot, high for exactly len_in cycles after start
module bpa_oneshot #(
    parameter int W = 16
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clear_in,
    input wire logic start_in,
    input wire logic [W-1:0] len_in,
    output logic active_out
);
    logic [W-1:0] cnt;

    // count down the remaining width
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt <= '0;
            active_out <= 1'b0;
        end else if (clear_in) begin
            cnt <= '0;
            active_out <= 1'b0;
        end else if (start_in && len_in != '0) begin
            cnt <= len_in;
            active_out <= 1'b1;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
            active_out <= (cnt != {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule

// File: logic/bpa_printer.sv
`timescale 1ns/100ps
// How it works
// - belt go gates the belt oscillator
// - belt motion up at speed, down ten percent
// - home and subscan only once up to speed
// - subscans from marks, dummy one at home
// - impression window from subscan fall, 235-435 us
// - fire line n drives hammer n only
// - per group report odd number of hammers on
// - carriage go makes advance pulses, eight per line
// - home pulse marks start of type set
// - forms sensed line shows forms present
// - overheat shown on thermal line and indicator
// - interlock switch pulls low when pushed in
// - two delayed advance pulses after carriage go drops
module bpa_printer
    import bpa_pkg::*;
#(
    parameter int IMP_MIN = bpa_pkg::IMP_MIN_CYC,
    parameter int IMP_STEP = bpa_pkg::IMP_STEP_CYC,
    parameter int CARR_STEP = bpa_pkg::CARR_STEP_CYC,
    parameter int CARR_DECEL = bpa_pkg::CARR_DECEL_CYC,
    parameter int MARK_CYC = bpa_pkg::BELT_MARK_CYC
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [bpa_pkg::REG_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [bpa_pkg::REG_W-1:0] reg_rdata_out,
    input wire logic printer_reset_in,
    input wire logic contactor_close_in,
    input wire logic belt_go_in,
    input wire logic carriage_go_in,
    input wire logic stop_ribbon_in,
    input wire logic paper_clamp_in,
    input wire logic [bpa_pkg::HAMMERS-1:0] fire_hammer_in,
    input wire logic timing_mark_in,
    input wire logic throat_plunger_in,
    input wire logic cover_plunger_in,
    input wire logic forms_plunger_in,
    input wire logic overtemp_in,
    output logic belt_motion_out,
    output logic belt_subscan_pulse_out,
    output logic impression_window_pulse_out,
    output logic home_pulse_out,
    output logic carriage_advance_out,
    output logic [bpa_pkg::GROUPS-1:0] hammer_check_out,
    output logic throat_closed_n_out,
    output logic cover_closed_n_out,
    output logic forms_sensed_n_out,
    output logic thermal_switch_out,
    output logic overtemperature_indicator_out,
    output logic [bpa_pkg::HAMMERS-1:0] hammer_coil_out,
    output logic supply_24v_out,
    output logic [3:0] belt_motor_out,
    output logic [3:0] carriage_motor_out,
    output logic ribbon_clutch_out,
    output logic clamp_solenoid_out
);
    import bpa_pkg::*;

    // speed limits from the nominal mark spacing
    localparam int DROP_CYC = MARK_CYC * 10 / 9;
    localparam int HOME_CYC = MARK_CYC * 3 / 2;
    localparam int SUBSCAN_CYC = MARK_CYC / 2;
    localparam int CW = 16;
    localparam int KW = 22;

    logic [HAMMERS+5:0] att_s;
    logic [4:0] sen_s;
    logic prst, contactor_s, belt_go_s, carr_go_s, stop_ribbon_s, clamp_s;
    logic [HAMMERS-1:0] fire_s;
    logic mark_s, mark_d, mark_rise;
    logic throat_s, cover_s, forms_s, hot_s;
    logic [2:0] thick;
    logic [CW-1:0] mark_cnt, interval, imp_len;
    logic home_gap, home_start, subscan_start, subscan_fall, subscan_d;
    logic [CW-1:0] belt_div, belt_tick;
    logic [1:0] belt_phase, carr_phase, carr_tail;
    logic [KW-1:0] carr_cnt;
    logic carr_go_d, adv_start;

    // attachment lines and printer sensors come from other logic and pins
    bpa_sync #(.W(HAMMERS + 6)) u_sync_att (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .pin_in({printer_reset_in, contactor_close_in, belt_go_in, carriage_go_in,
                 stop_ribbon_in, paper_clamp_in, fire_hammer_in}),
        .sync_out(att_s)
    );
    bpa_sync #(.W(5)) u_sync_sen (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .pin_in({timing_mark_in, throat_plunger_in, cover_plunger_in, forms_plunger_in,
                 overtemp_in}),
        .sync_out(sen_s)
    );
    assign {prst, contactor_s, belt_go_s, carr_go_s, stop_ribbon_s, clamp_s} =
        att_s[HAMMERS+5:HAMMERS];
    assign fire_s = att_s[HAMMERS-1:0];
    assign {mark_s, throat_s, cover_s, forms_s, hot_s} = sen_s;
    assign mark_rise = mark_s & ~mark_d;

    // hammer drive, supply contactor and solenoids; printer reset drops them
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hammer_coil_out <= '0;
            supply_24v_out <= 1'b0;
            ribbon_clutch_out <= 1'b0;
            clamp_solenoid_out <= 1'b0;
        end else if (prst) begin
            hammer_coil_out <= '0;
            supply_24v_out <= 1'b0;
            ribbon_clutch_out <= 1'b0;
            clamp_solenoid_out <= 1'b0;
        end else begin
            supply_24v_out <= contactor_s;
            hammer_coil_out <= fire_s & {HAMMERS{contactor_s}};
            ribbon_clutch_out <= ~stop_ribbon_s;
            clamp_solenoid_out <= clamp_s;
        end
    end

    // odd parity per driver card, taken from what is really driven
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hammer_check_out <= '0;
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                hammer_check_out[g] <= ^hammer_coil_out[g*GROUP_SIZE +: GROUP_SIZE];
            end
        end
    end

    // interlocks read low when the plunger is in; overheat lamp follows the switch
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            throat_closed_n_out <= 1'b1;
            cover_closed_n_out <= 1'b1;
            forms_sensed_n_out <= 1'b1;
            thermal_switch_out <= 1'b0;
            overtemperature_indicator_out <= 1'b0;
        end else begin
            throat_closed_n_out <= ~throat_s;
            cover_closed_n_out <= ~cover_s;
            forms_sensed_n_out <= ~forms_s;
            thermal_switch_out <= hot_s;
            overtemperature_indicator_out <= hot_s;
        end
    end

    // belt oscillator ramps its step period down to running speed
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            belt_div <= CW'(BELT_START_DIV);
            belt_tick <= '0;
            belt_phase <= 2'h0;
        end else if (prst || !belt_go_s) begin
            belt_div <= CW'(BELT_START_DIV);
            belt_tick <= '0;
        end else if (belt_tick >= belt_div - 1'b1) begin
            belt_tick <= '0;
            belt_phase <= belt_phase + 1'b1;
            if (belt_div > CW'(BELT_RUN_DIV)) begin
                belt_div <= belt_div - 1'b1;
            end
        end else begin
            belt_tick <= belt_tick + 1'b1;
        end
    end

    // two-phase drive pattern for a stepper: a, a_bar, b, b_bar
    function automatic logic [3:0] phase_drive(input logic [1:0] ph);
        logic [3:0] d;
        d = 4'h0;
        case (ph)
            2'h0: d = 4'ha;
            2'h1: d = 4'h6;
            2'h2: d = 4'h5;
            default: d = 4'h9;
        endcase
        return d;
    endfunction
    assign belt_motor_out = belt_go_s ? phase_drive(belt_phase) : 4'h0;
    assign carriage_motor_out = phase_drive(carr_phase);

    // mark spacing sets speed status; the missing mark gives home
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mark_d <= 1'b0;
            mark_cnt <= '1; // no spacing measured yet
            interval <= '0;
            home_gap <= 1'b0;
            belt_motion_out <= 1'b0;
        end else if (prst) begin
            mark_d <= mark_s;
            mark_cnt <= '1;
            home_gap <= 1'b0;
            belt_motion_out <= 1'b0;
        end else begin
            mark_d <= mark_s;
            if (mark_rise) begin
                mark_cnt <= '0;
                interval <= mark_cnt;
                home_gap <= 1'b0;
                if (home_gap ? (mark_cnt > CW'(2 * DROP_CYC)) : (mark_cnt > CW'(DROP_CYC))) begin
                    belt_motion_out <= 1'b0;
                end else if (mark_cnt <= CW'(MARK_CYC) && belt_go_s) begin
                    belt_motion_out <= 1'b1;
                end
            end else begin
                if (!belt_go_s) begin
                    mark_cnt <= '1; // a stale count must not pass as speed
                end else if (mark_cnt != '1) begin
                    mark_cnt <= mark_cnt + 1'b1;
                end
                if (mark_cnt > CW'(2 * DROP_CYC)) begin
                    belt_motion_out <= 1'b0;
                end
                if (home_start) begin
                    home_gap <= 1'b1;
                end
            end
        end
    end

    // a long gap while at speed is the home position; slow belts never reach it
    assign home_start = belt_motion_out && !home_gap && !mark_rise && mark_cnt == CW'(HOME_CYC);
    assign subscan_start = belt_motion_out && (mark_rise || home_start);

    bpa_oneshot #(.W(CW)) u_subscan (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(prst),
        .start_in(subscan_start),
        .len_in(CW'(SUBSCAN_CYC)),
        .active_out(belt_subscan_pulse_out)
    );
    bpa_oneshot #(.W(CW)) u_home (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(prst),
        .start_in(home_start),
        .len_in(CW'(PULSE_CYC)),
        .active_out(home_pulse_out)
    );

    // impression window starts as the subscan falls
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            subscan_d <= 1'b0;
        end else begin
            subscan_d <= belt_subscan_pulse_out;
        end
    end
    assign subscan_fall = subscan_d & ~belt_subscan_pulse_out;

    bpa_oneshot #(.W(CW)) u_impression (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(prst),
        .start_in(subscan_fall),
        .len_in(CW'(IMP_MIN + int'(thick) * IMP_STEP)),
        .active_out(impression_window_pulse_out)
    );

    // carriage oscillator, then two slow steps to stop without overshoot
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            carr_cnt <= '0;
            carr_tail <= 2'h0;
            carr_go_d <= 1'b0;
            carr_phase <= 2'h0;
        end else if (prst) begin
            carr_cnt <= '0;
            carr_tail <= 2'h0;
            carr_go_d <= 1'b0;
        end else begin
            carr_go_d <= carr_go_s;
            if (carr_go_s) begin
                carr_tail <= 2'h0;
                carr_cnt <= (carr_cnt >= KW'(CARR_STEP - 1)) ? '0 : carr_cnt + 1'b1;
            end else if (carr_go_d) begin
                carr_tail <= CARR_TAIL_STEPS;
                carr_cnt <= '0;
            end else if (carr_tail != 2'h0) begin
                if (carr_cnt >= KW'(CARR_DECEL - 1)) begin
                    carr_cnt <= '0;
                    carr_tail <= carr_tail - 1'b1;
                end else begin
                    carr_cnt <= carr_cnt + 1'b1;
                end
            end
            if (adv_start) begin
                carr_phase <= carr_phase + 1'b1;
            end
        end
    end
    assign adv_start = !prst && ((carr_go_s && carr_cnt >= KW'(CARR_STEP - 1)) ||
        (!carr_go_s && !carr_go_d && carr_tail != 2'h0 && carr_cnt >= KW'(CARR_DECEL - 1)));

    bpa_oneshot #(.W(CW)) u_advance (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(prst),
        .start_in(adv_start),
        .len_in(CW'(PULSE_CYC)),
        .active_out(carriage_advance_out)
    );

    // control register: forms thickness steers the impression window
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            thick <= CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == CTRL_ADDR) begin
            thick <= reg_wdata_in[CTRL_THICK_LSB +: 3];
        end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= '0;
            case (reg_addr_in)
                CTRL_ADDR: reg_rdata_out[CTRL_THICK_LSB +: 3] <= thick;
                STATUS_ADDR: begin
                    reg_rdata_out[ST_MOTION] <= belt_motion_out;
                    reg_rdata_out[ST_CARRIAGE] <= carr_go_s | (carr_tail != 2'h0);
                    reg_rdata_out[ST_GAP] <= home_gap;
                    reg_rdata_out[ST_HCHK_LSB +: GROUPS] <= hammer_check_out;
                    reg_rdata_out[ST_THROAT] <= ~throat_closed_n_out;
                    reg_rdata_out[ST_COVER] <= ~cover_closed_n_out;
                    reg_rdata_out[ST_FORMS] <= ~forms_sensed_n_out;
                    reg_rdata_out[ST_THERMAL] <= thermal_switch_out;
                    reg_rdata_out[ST_SUPPLY] <= supply_24v_out;
                end
                INTERVAL_ADDR: reg_rdata_out[CW-1:0] <= interval;
                default: reg_rdata_out <= '0;
            endcase
        end
    end

    // width of each impression window, seen only by the checks below
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            imp_len <= '0;
        end else if (impression_window_pulse_out) begin
            imp_len <= imp_len + 1'b1;
        end else begin
            imp_len <= '0;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    property p_hammer_map;
        !$past(prst) |-> hammer_coil_out == ($past(fire_s) & {HAMMERS{$past(contactor_s)}});
    endproperty
    a_hammer_map: assert property (p_hammer_map) else $error("hammer line mismatch");
    property p_supply;
        $fell(contactor_s) && !prst |=> !supply_24v_out && hammer_coil_out == '0;
    endproperty
    a_supply: assert property (p_supply) else $error("supply not dropped");
    property p_parity;
        ##1 hammer_check_out[1] == ^$past(hammer_coil_out[GROUP_SIZE +: GROUP_SIZE]);
    endproperty
    a_parity: assert property (p_parity) else $error("group parity wrong");
    property p_imp_start;
        $fell(belt_subscan_pulse_out) && !prst |=> impression_window_pulse_out;
    endproperty
    a_imp_start: assert property (p_imp_start) else $error("window not started");
    property p_imp_len;
        $fell(impression_window_pulse_out) && !$past(prst) |->
            imp_len >= CW'(IMP_MIN) && imp_len <= CW'(IMP_MIN + THICK_STEPS * IMP_STEP);
    endproperty
    a_imp_len: assert property (p_imp_len) else $error("window width out of range");
    property p_subscan_speed;
        $rose(belt_subscan_pulse_out) |-> $past(belt_motion_out);
    endproperty
    a_subscan_speed: assert property (p_subscan_speed) else $error("subscan below speed");
    property p_home_dummy;
        $rose(home_pulse_out) |-> belt_subscan_pulse_out && !$past(mark_rise);
    endproperty
    a_home_dummy: assert property (p_home_dummy) else $error("no dummy subscan at home");
    property p_slow_drop;
        mark_cnt > CW'(2 * DROP_CYC) && !mark_rise && !prst |=> !belt_motion_out;
    endproperty
    a_slow_drop: assert property (p_slow_drop) else $error("motion kept when slow");
    property p_tail;
        $fell(carr_go_s) && !prst && !$past(prst) |=> carr_tail == CARR_TAIL_STEPS;
    endproperty
    a_tail: assert property (p_tail) else $error("stopping steps not loaded");
    property p_adv_cause;
        $rose(carriage_advance_out) |-> $past(carr_go_s) || $past(carr_tail != 2'h0);
    endproperty
    a_adv_cause: assert property (p_adv_cause) else $error("stray advance pulse");
    property p_interlock;
        ##1 throat_closed_n_out == !$past(throat_s) && cover_closed_n_out == !$past(cover_s);
    endproperty
    a_interlock: assert property (p_interlock) else $error("interlock level wrong");
    property p_thermal;
        ##1 thermal_switch_out == $past(hot_s) && overtemperature_indicator_out == $past(hot_s);
    endproperty
    a_thermal: assert property (p_thermal) else $error("indicator not lit");

    c_home: cover property ($rose(home_pulse_out));
    c_impression: cover property ($fell(impression_window_pulse_out));
    c_tail: cover property ($rose(carriage_advance_out) && !carr_go_s);
    c_motion_lost: cover property ($fell(belt_motion_out));
endmodule

// File: tb/bpa_attach_model.sv
`timescale 1ns/100ps
// attachment side: runs carriage go and counts advance pulses to stop it
module bpa_attach_model #(
    parameter int MISS_CYC = 320000
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic carriage_advance_in,
    output logic carriage_go_out,
    output logic sync_check_out
);
    logic [1:0] adv_sync;
    logic [3:0] adv_seen;
    logic adv_edge;
    int gap;
    assign adv_edge = adv_sync[0] && !adv_sync[1];
    // go drops after six pulses; the printer then adds its two stopping steps
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            adv_sync <= 2'h0;
            adv_seen <= 4'h0;
            carriage_go_out <= 1'b0;
        end else begin
            adv_sync <= {adv_sync[0], carriage_advance_in};
            if (start_in) begin
                carriage_go_out <= 1'b1;
                adv_seen <= 4'h0;
            end else if (adv_sync[0] && !adv_sync[1]) begin
                adv_seen <= adv_seen + 4'h1;
                if (adv_seen == 4'h5) carriage_go_out <= 1'b0;
            end
        end
    end
    // sync check: a pulse with no motion started, or none in time while spacing
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gap <= 0;
            sync_check_out <= 1'b0;
        end else begin
            gap <= (adv_edge || !carriage_go_out) ? 0 : gap + 1;
            if (adv_edge && !carriage_go_out && adv_seen != 4'h6 && adv_seen != 4'h7) begin
                sync_check_out <= 1'b1;
            end
            if (gap >= MISS_CYC) begin
                sync_check_out <= 1'b1;
            end
        end
    end
endmodule

// File: tb/belt_printer_attachment_lines_bench.sv
`timescale 1ns/100ps
module belt_printer_attachment_lines_bench;
    import bpa_pkg::*;
    localparam int IMPM = 40;
    localparam int IMPS = 4;
    logic clk = 0, rst = 1, wr = 0, rd = 0, prst = 0, cont = 0, bgo = 0, cstart = 0, cgo;
    logic srib = 0, clamp = 0, mark = 0, thr = 0, cov = 0, frm = 0, ot = 0;
    logic [3:0] addr = 4'h0, bmot;
    logic [31:0] wd = 32'h0, rdata, d;
    logic [65:0] fire = 66'h0, coil;
    logic motion, sub, imp, home, adv, thn, cvn, fmn, ts, oti, sup, rib, cls, imp_q, adv_q, home_q;
    logic [2:0] hchk;
    logic schk;
    logic [3:0] cmot;
    int hs_cnt = 0;
    int n_fail = 0, cmp_count = 0, imp_run = 0, imp_len = 0, adv_cnt = 0, home_cnt = 0;
    bpa_printer #(.IMP_MIN(IMPM), .IMP_STEP(IMPS), .CARR_STEP(50), .CARR_DECEL(100),
        .MARK_CYC(200)) dut (.clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .printer_reset_in(prst), .contactor_close_in(cont), .belt_go_in(bgo),
        .carriage_go_in(cgo), .stop_ribbon_in(srib), .paper_clamp_in(clamp),
        .fire_hammer_in(fire & {66{imp | ~bgo}}),
        .timing_mark_in(mark), .throat_plunger_in(thr),
        .cover_plunger_in(cov), .forms_plunger_in(frm), .overtemp_in(ot),
        .belt_motion_out(motion), .belt_subscan_pulse_out(sub),
        .impression_window_pulse_out(imp), .home_pulse_out(home),
        .carriage_advance_out(adv), .hammer_check_out(hchk), .throat_closed_n_out(thn),
        .cover_closed_n_out(cvn), .forms_sensed_n_out(fmn), .thermal_switch_out(ts),
        .overtemperature_indicator_out(oti), .hammer_coil_out(coil), .supply_24v_out(sup),
        .belt_motor_out(bmot), .carriage_motor_out(cmot), .ribbon_clutch_out(rib),
        .clamp_solenoid_out(cls));
    bpa_attach_model #(.MISS_CYC(200)) partner (.clk_sys_in(clk), .sys_rst_in(rst),
        .start_in(cstart), .carriage_advance_in(adv), .carriage_go_out(cgo),
        .sync_check_out(schk));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // pulse widths and edge counts, measured independently of the design
    always @(posedge clk) begin
        imp_run <= imp ? imp_run + 1 : 0;
        if (imp_q && !imp) imp_len <= imp_run;
        if (adv && !adv_q) adv_cnt <= adv_cnt + 1;
        if (home && !home_q) home_cnt <= home_cnt + 1;
        if (home && !home_q && sub) hs_cnt <= hs_cnt + 1;
        imp_q <= imp;
        adv_q <= adv;
        home_q <= home;
    end
    task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // marks spaced gap cycles apart, sensor high for ten cycles
    task automatic marks(input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            mark <= 1'b1;
            repeat (10) @(posedge clk);
            mark <= 1'b0;
            repeat (gap - 11) @(posedge clk);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        chk("idle_n", 3'h7, {thn, cvn, fmn});
        chk("belt_off", 4'h0, bmot);
        rreg(CTRL_ADDR, d);
        chk("ctrl_rst", 32'h0, d);
        rreg(4'hc, d);
        chk("unmapped", 32'h0, d);
        wreg(CTRL_ADDR, 32'h3);
        rreg(CTRL_ADDR, d);
        chk("ctrl", 32'h3, d);
        @(posedge clk);
        {thr, cov, frm, ot, srib, clamp} <= 6'h3f;
        wt(4);
        chk("interlock", 3'h0, {thn, cvn, fmn});
        chk("thermal", 2'h3, {ts, oti});
        chk("rib_clamp", 2'h1, {rib, cls});
        rreg(STATUS_ADDR, d);
        chk("status", 4'hf, d[9:6]);
        @(posedge clk);
        fire <= {22'h0, 22'h3, 22'h1};
        wt(5);
        chk("coil_off", 66'h0, coil);
        @(posedge clk);
        cont <= 1'b1;
        wt(5);
        chk("coil", fire, coil);
        chk("hchk", 3'h1, hchk);
        chk("supply", 1'b1, sup);
        @(posedge clk);
        bgo <= 1'b1;
        chk("early_home", 0, home_cnt);
        marks(4, 200);
        wt(1);
        chk("motion", 1'b1, motion);
        chk("imp_len", IMPM + 3 * IMPS, imp_len);
        chk("coil_gated", 66'h0, coil);
        marks(1, 400);
        marks(2, 200);
        chk("home", 1, home_cnt);
        chk("home_subscan", 1, hs_cnt);
        marks(3, 300);
        wt(1);
        chk("drop", 1'b0, motion);
        @(posedge clk);
        cstart <= 1'b1;
        @(posedge clk);
        cstart <= 1'b0;
        wt(1200);
        chk("advances", 8, adv_cnt);
        chk("sync_chk", 1'b0, schk);
        chk("carr_drive", 4'ha, cmot);
        @(posedge clk);
        prst <= 1'b1;
        wt(5);
        chk("reset_supply", 1'b0, sup);
        conclude;
    end
endmodule
